// ===== design/coc_ctrl.sv
/*
  Two-channel 4-20 mA current output control: output words, fallback,
  per-channel enable, status words and fault indicators.
  Assumes the island interface logic shares mclk, presents one output word
  write at a time, and drives commOk low while communication is lost.
  Fault sense pins are asynchronous and are synchronised here.
*/
// What this block does
// - On communication loss each enabled channel enters its fallback state until restored.
// - Format with -1000..32767 range maps 0 to 4 mA, 32000 to 20 mA.
// - Format with 0..65535 range maps 0 to 4 mA, 64000 to 20 mA, never below 4.
// - Configuration defaults every channel to predefined fallback worth 4 mA.
// - Hold-last-value mode ignores the stored fallback and keeps the last output.
// - Channels enable individually and come up enabled after auto configuration.
// - A disabled channel drives minimum current and drops writes to its word.
// - A disabled channel reports an all-zero status word and a dark indicator.
// - Current equals count/2000+4 mA signed, count/4000+4 mA unsigned.
// - Two contiguous status words are reported, channel 1 first.
// - Global status bit 0 follows only the hardware fault bit.
// - Bit 2 warns when signed data exceeds 32000 or unsigned exceeds 64000.
// - Bit 3 errs when signed data reaches 32767 or unsigned reaches 65535.
// - Bit 4 warns, signed format only, when data is below zero.
// - Bit 5 errs, signed format only, when data is at or below -1000.
// - Bit 6 shows a broken wire or unpowered channel.
`include "coc_params.svh"

module coc_ctrl
  import coc_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = `COC_BLINK_HALF_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic autoConfig,
  input wire logic cfgWrite,
  input wire logic cfgChan,
  input wire logic cfgEnable,
  input wire logic cfgHoldLast,
  input wire logic [15:0] cfgFallback,
  input wire logic cfgUnsigned,
  input wire logic outWrite,
  input wire logic outChan,
  input wire logic [15:0] outData,
  input wire logic commOk,
  input wire logic [1:0] wireBrokenPin,
  input wire logic [1:0] powerLostPin,
  output logic [15:0] outWord0,
  output logic [15:0] outWord1,
  output logic [15:0] statusWord0,
  output logic [15:0] statusWord1,
  output logic [15:0] setpointUa0,
  output logic [15:0] setpointUa1,
  output logic [1:0] faultLed
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] legalize(input logic [15:0] v, input coc_fmt_t f);
    logic [15:0] r;
    r = v;
    // The lone signed code without a positive twin is pulled in by one
    if (f == COC_FMT_SIGNED && v == `COC_SGN_MOST_NEG)
    begin
      r = `COC_SGN_LEAST_LEGAL;
    end
    return r;
  endfunction

  function automatic logic [15:0] status(input logic [15:0] v, input coc_fmt_t f,
                                         input logic hardware_fault_flag, input logic en);
    logic [15:0] s;
    s = 16'h0000;
    if (en)
    begin
      if (f == COC_FMT_SIGNED)
      begin
        s[`COC_BIT_OCW] = $signed(v) > $signed(`COC_SGN_OCW_LIMIT);
        s[`COC_BIT_OCE] = $signed(v) >= $signed(`COC_SGN_OCE_LIMIT);
        s[`COC_BIT_UCW] = $signed(v) < $signed(16'h0000);
        s[`COC_BIT_UCE] = $signed(v) <= $signed(`COC_SGN_UCE_LIMIT);
      end
      else
      begin
        s[`COC_BIT_OCW] = v > `COC_UNS_OCW_LIMIT;
        s[`COC_BIT_OCE] = v >= `COC_UNS_OCE_LIMIT;
      end
      s[`COC_BIT_HWE] = hardware_fault_flag;
      s[`COC_BIT_GLOBAL] = hardware_fault_flag;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  coc_fmt_t fmt;
  logic [1:0] chanEn;
  coc_fbmode_t fbMode [2];
  logic [15:0] fbValue [2];
  logic [15:0] outWord [2];
  logic [15:0] effValue [2];
  coc_chan_t chanState [2];
  coc_chan_t next_chanState [2];
  logic [1:0] wireMeta;
  logic [1:0] wireSync;
  logic [1:0] powerMeta;
  logic [1:0] powerSync;
  logic [1:0] hwFault;
  logic [31:0] blinkCount;
  logic blinkPhase;
  logic [15:0] statusWord [2];
  logic [15:0] setpoint [2];

  // ----------------------------------------------------------------------
  // Fault pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wireMeta <= 2'h0;
      wireSync <= 2'h0;
      powerMeta <= 2'h0;
      powerSync <= 2'h0;
    end
    else
    begin
      wireMeta <= wireBrokenPin;
      wireSync <= wireMeta;
      powerMeta <= powerLostPin;
      powerSync <= powerMeta;
    end
  end

  assign hwFault = wireSync | powerSync;

  // ----------------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------------
  // Auto configuration restores the same defaults as reset
  always_ff @(posedge mclk)
  begin
    if (rst || autoConfig)
    begin
      fmt <= coc_fmt_t'(`COC_RST_UNSIGNED);
      chanEn <= {2{`COC_RST_ENABLE}};
      for (int i = 0; i < 2; i++)
      begin
        fbMode[i] <= coc_fbmode_t'(`COC_RST_HOLD);
        fbValue[i] <= `COC_RST_FALLBACK;
      end
    end
    else if (cfgWrite)
    begin
      fmt <= cfgUnsigned ? COC_FMT_UNSIGNED : COC_FMT_SIGNED;
      chanEn[cfgChan] <= cfgEnable;
      fbMode[cfgChan] <= cfgHoldLast ? COC_FB_HOLD : COC_FB_PREDEF;
      fbValue[cfgChan] <= cfgFallback;
    end
  end

  // ----------------------------------------------------------------------
  // Output data words
  // ----------------------------------------------------------------------
  // Writes while the link is down are dropped; the channel stays in fallback
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      outWord[0] <= `COC_RST_OUTWORD;
      outWord[1] <= `COC_RST_OUTWORD;
    end
    else if (outWrite && commOk && chanEn[outChan])
    begin
      outWord[outChan] <= legalize(outData, fmt);
    end
  end

  // ----------------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      case (chanState[i])
        COC_ST_RUN:
        begin
          if (!chanEn[i])
          begin
            next_chanState[i] = COC_ST_OFF;
          end
          else if (!commOk)
          begin
            next_chanState[i] = COC_ST_FALLBACK;
          end
          else
          begin
            next_chanState[i] = COC_ST_RUN;
          end
        end
        COC_ST_FALLBACK:
        begin
          if (!chanEn[i])
          begin
            next_chanState[i] = COC_ST_OFF;
          end
          else if (commOk)
          begin
            next_chanState[i] = COC_ST_RUN;
          end
          else
          begin
            next_chanState[i] = COC_ST_FALLBACK;
          end
        end
        COC_ST_OFF:
        begin
          if (!chanEn[i])
          begin
            next_chanState[i] = COC_ST_OFF;
          end
          else if (commOk)
          begin
            next_chanState[i] = COC_ST_RUN;
          end
          else
          begin
            next_chanState[i] = COC_ST_FALLBACK;
          end
        end
        default:
        begin
          next_chanState[i] = COC_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      chanState[0] <= COC_ST_RUN;
      chanState[1] <= COC_ST_RUN;
    end
    else
    begin
      chanState[0] <= next_chanState[0];
      chanState[1] <= next_chanState[1];
    end
  end

  // ----------------------------------------------------------------------
  // Value applied to each channel
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      effValue[0] <= `COC_RST_FALLBACK;
      effValue[1] <= `COC_RST_FALLBACK;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        case (next_chanState[i])
          COC_ST_RUN:
          begin
            effValue[i] <= outWord[i];
          end
          COC_ST_FALLBACK:
          begin
            // Hold mode keeps the value already applied
            if (fbMode[i] == COC_FB_PREDEF)
            begin
              effValue[i] <= legalize(fbValue[i], fmt);
            end
            else
            begin
              effValue[i] <= effValue[i];
            end
          end
          COC_ST_OFF:
          begin
            effValue[i] <= effValue[i];
          end
          default:
          begin
            effValue[i] <= effValue[i];
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Converters
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gConv
    coc_setpoint uConv
    (
      .mclk(mclk),
      .rst(rst),
      .value(effValue[g]),
      .fmt(fmt),
      .enabled(chanState[g] != COC_ST_OFF),
      .setpointUa(setpoint[g])
    );
  end

  // ----------------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      statusWord[0] <= 16'h0000;
      statusWord[1] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        statusWord[i] <= status(effValue[i], fmt, hwFault[i],
                                chanState[i] != COC_ST_OFF);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault indicators
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      blinkCount <= 32'h00000000;
      blinkPhase <= 1'b0;
    end
    else if (blinkCount >= BLINK_HALF_CYC - 1)
    begin
      blinkCount <= 32'h00000000;
      blinkPhase <= ~blinkPhase;
    end
    else
    begin
      blinkCount <= blinkCount + 32'h00000001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      faultLed <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        faultLed[i] <= blinkPhase && hwFault[i] && chanState[i] != COC_ST_OFF;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign outWord0 = outWord[0];
  assign outWord1 = outWord[1];
  assign statusWord0 = statusWord[0];
  assign statusWord1 = statusWord[1];
  assign setpointUa0 = setpoint[0];
  assign setpointUa1 = setpoint[1];

endmodule

// ===== design/coc_params.svh
/*
  Constants of the two-channel current output control: status bit positions,
  data thresholds, reset values and timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef COC_PARAMS_SVH
`define COC_PARAMS_SVH

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define COC_BIT_GLOBAL 0
`define COC_BIT_OCW 2
`define COC_BIT_OCE 3
`define COC_BIT_UCW 4
`define COC_BIT_UCE 5
`define COC_BIT_HWE 6

// ----------------------------------------------------------------------
// Data thresholds and limits
// ----------------------------------------------------------------------
`define COC_SGN_OCW_LIMIT 16'h7d00
`define COC_SGN_OCE_LIMIT 16'h7fff
`define COC_SGN_UCE_LIMIT 16'hfc18
`define COC_SGN_MOST_NEG 16'h8000
`define COC_SGN_LEAST_LEGAL 16'h8001
`define COC_UNS_OCW_LIMIT 16'hfa00
`define COC_UNS_OCE_LIMIT 16'hffff

// ----------------------------------------------------------------------
// Current scaling, in microamps
// ----------------------------------------------------------------------
`define COC_BASE_UA 17'h00fa0
`define COC_MIN_UA 16'h0000

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define COC_RST_FALLBACK 16'h0000
`define COC_RST_OUTWORD 16'h0000
`define COC_RST_ENABLE 1'b1
`define COC_RST_HOLD 1'b0
`define COC_RST_UNSIGNED 1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define COC_CLK_KHZ 20000
`define COC_BLINK_HALF_MS 250
`define COC_BLINK_HALF_CYC (`COC_BLINK_HALF_MS * `COC_CLK_KHZ)

`endif

// ===== design/coc_pkg.sv
/*
  Types shared by the current output control modules.
  Assumes coc_params.svh is on the include path.
*/
`include "coc_params.svh"

package coc_pkg;

  typedef enum logic {COC_FMT_SIGNED, COC_FMT_UNSIGNED} coc_fmt_t;

  typedef enum logic {COC_FB_PREDEF, COC_FB_HOLD} coc_fbmode_t;

  typedef enum logic [1:0] {COC_ST_RUN, COC_ST_FALLBACK, COC_ST_OFF} coc_chan_t;

endpackage

// ===== design/coc_setpoint.sv
/*
  One channel's count-to-current converter with a registered setpoint.
  Assumes the value is already range-checked and that mclk and rst are
  the control's own clock and synchronous reset.
*/
`include "coc_params.svh"

module coc_setpoint
  import coc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] value,
  input wire coc_fmt_t fmt,
  input wire logic enabled,
  output logic [15:0] setpointUa
);

  logic [16:0] sum;

  // ----------------------------------------------------------------------
  // Scaling: signed count/2 uA, unsigned count/4 uA, above 4 mA
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (fmt == COC_FMT_UNSIGNED)
    begin
      sum = `COC_BASE_UA + {3'h0, value[15:2]};
    end
    else
    begin
      sum = `COC_BASE_UA + {{2{value[15]}}, value[15:1]};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      setpointUa <= `COC_MIN_UA;
    end
    else if (!enabled)
    begin
      setpointUa <= `COC_MIN_UA;
    end
    else if (fmt == COC_FMT_SIGNED && sum[16])
    begin
      // Counts below -8000 would ask for negative current; stop at zero
      setpointUa <= `COC_MIN_UA;
    end
    else
    begin
      setpointUa <= sum[15:0];
    end
  end

endmodule

// ===== verification/coc_ctrl_checker.sv
/*
  Port checker of the current output control, bound into coc_ctrl.
  Assumes mclk and a synchronous active-high rst.
*/
// ----
// Relations
// ----
module coc_ctrl_checker
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic outWrite,
  input wire logic outChan,
  input wire logic commOk,
  input wire logic [15:0] outWord0,
  input wire logic [15:0] statusWord0,
  input wire logic [15:0] statusWord1,
  input wire logic [15:0] setpointUa0,
  input wire logic [1:0] faultLed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_global_tracks_hw: assert property (statusWord0[0] == statusWord0[6])
    else $error("global flag differs from hardware flag");
  a_unused_bits_zero: assert property ({statusWord0[15:7], statusWord0[1],
    statusWord1[15:7], statusWord1[1]} == 20'h00000)
    else $error("unassigned status bit set");
  a_error_needs_warn: assert property (statusWord0[3] |-> statusWord0[2])
    else $error("over error without over warning");
  a_under_err_warn: assert property (statusWord0[5] |-> statusWord0[4])
    else $error("under error without under warning");
  a_under_not_over: assert property (statusWord1[4] |-> !statusWord1[2])
    else $error("under and over warning together");
  a_lost_write_dropped: assert property (outWrite && !commOk && !outChan
    |=> $stable(outWord0))
    else $error("word taken while link lost");
  a_setpoint_ceiling: assert property (setpointUa0 <= 16'h4fa0)
    else $error("setpoint above full scale");
  a_led_dark_idle: assert property ((statusWord0[6] == 1'b0) [*8] |-> !faultLed[0])
    else $error("indicator lit without fault");
  a_reset_clears: assert property (disable iff (1'b0) rst |=> outWord0 == 16'h0000
    && statusWord0 == 16'h0000 && faultLed == 2'b00)
    else $error("outputs not cleared by reset");
endmodule

bind coc_ctrl coc_ctrl_checker chk (.mclk(mclk), .rst(rst), .outWrite(outWrite),
  .outChan(outChan), .commOk(commOk), .outWord0(outWord0), .statusWord0(statusWord0),
  .statusWord1(statusWord1), .setpointUa0(setpointUa0), .faultLed(faultLed));

// ===== verification/coc_island_model.sv
/*
  Behavioural island interface: sends output word pairs and link state.
  Assumes the bench calls its tasks; mclk is the control's clock.
*/
module coc_island_model
(
  input wire logic mclk,
  output logic outWrite,
  output logic outChan,
  output logic [15:0] outData,
  output logic commOk
);
  initial
  begin
    outWrite = 1'b0;
    outChan = 1'b0;
    outData = 16'h0000;
    commOk = 1'b1;
  end
  // ----
  // Transfers
  // ----
  // Idle data shows the inverse word, so a stale value never passes
  task automatic sendPair(input logic [15:0] d0, input logic [15:0] d1, input int gap);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      outWrite <= 1'b1;
      outChan <= i[0];
      outData <= i[0] ? d1 : d0;
      if (gap > 0)
      begin
        @(posedge mclk);
        outWrite <= 1'b0;
        outData <= ~outData;
        repeat (gap - 1) @(posedge mclk);
      end
    end
    if (gap == 0)
    begin
      @(posedge mclk);
      outWrite <= 1'b0;
      outData <= ~outData;
    end
  endtask
  task automatic link(input logic up);
    @(posedge mclk);
    commOk <= up;
  endtask
endmodule

// ===== verification/test_current_output_channel_ctrl.sv
/*
  Self-checking bench of the current output control with the island model.
  Assumes the design files are compiled first.
*/
module test_current_output_channel_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, autoConfig, cfgWrite, cfgChan, cfgEnable, cfgHoldLast, cfgUnsigned;
  logic outWrite, outChan, commOk;
  logic [15:0] cfgFallback, outData, outWord0, outWord1, statusWord0, statusWord1;
  logic [15:0] setpointUa0, setpointUa1;
  logic [1:0] wireBrokenPin, powerLostPin, faultLed;
  int miscompares = 0;
  int checksDone = 0;
  logic [15:0] sgn [9] = '{16'h0000, 16'h7d00, 16'h7d01, 16'h7fff, 16'hffff,
    16'hfc19, 16'hfc18, 16'h8000, 16'h8001};
  logic [15:0] uns [6] = '{16'h0000, 16'hfa00, 16'hfa01, 16'hfffe, 16'hffff, 16'h8000};

  coc_ctrl #(.BLINK_HALF_CYC(4)) uut (.mclk(mclk), .rst(rst), .autoConfig(autoConfig),
    .cfgWrite(cfgWrite), .cfgChan(cfgChan), .cfgEnable(cfgEnable),
    .cfgHoldLast(cfgHoldLast), .cfgFallback(cfgFallback), .cfgUnsigned(cfgUnsigned),
    .outWrite(outWrite), .outChan(outChan), .outData(outData), .commOk(commOk),
    .wireBrokenPin(wireBrokenPin), .powerLostPin(powerLostPin), .outWord0(outWord0),
    .outWord1(outWord1), .statusWord0(statusWord0), .statusWord1(statusWord1),
    .setpointUa0(setpointUa0), .setpointUa1(setpointUa1), .faultLed(faultLed));
  coc_island_model isl (.mclk(mclk), .outWrite(outWrite), .outChan(outChan),
    .outData(outData), .commOk(commOk));

  // ----
  // Expectations and helpers
  // ----
  function automatic logic [15:0] expUa(input logic [15:0] v, input logic u);
    int s;
    s = u ? 4000 + int'(v >> 2) : 4000 + (int'($signed(v)) >>> 1);
    return (s < 0) ? 16'h0000 : 16'(s);
  endfunction
  function automatic logic [15:0] expSt(input logic [15:0] v, input logic u, input logic hw);
    int s;
    logic [15:0] r;
    s = int'($signed(v));
    r = 16'h0000;
    r[0] = hw;
    r[6] = hw;
    r[2] = u ? (v > 16'hfa00) : (s > 32000);
    r[3] = u ? (v == 16'hffff) : (s >= 32767);
    r[4] = !u && s < 0;
    r[5] = !u && s <= -1000;
    return r;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cfg(input logic ch, en, hold, input logic [15:0] fb, input logic u);
    @(posedge mclk);
    cfgWrite <= 1'b1;
    cfgChan <= ch;
    cfgEnable <= en;
    cfgHoldLast <= hold;
    cfgFallback <= fb;
    cfgUnsigned <= u;
    @(posedge mclk);
    cfgWrite <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic auto();
    @(posedge mclk);
    autoConfig <= 1'b1;
    @(posedge mclk);
    autoConfig <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic pair(input logic [15:0] a, b, input logic u, input int gap);
    logic [15:0] w0, w1;
    w0 = (!u && a == 16'h8000) ? 16'h8001 : a;
    w1 = (!u && b == 16'h8000) ? 16'h8001 : b;
    isl.sendPair(a, b, gap);
    repeat (5) @(posedge mclk);
    check("outWord0", outWord0, w0);
    check("outWord1", outWord1, w1);
    check("setpointUa0", setpointUa0, expUa(w0, u));
    check("setpointUa1", setpointUa1, expUa(w1, u));
    check("statusWord0", statusWord0, expSt(w0, u, 1'b0));
    check("statusWord1", statusWord1, expSt(w1, u, 1'b0));
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----
  // Clock, watchdog and tests
  // ----
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("watchdog expired");
    conclude();
  end
  initial
  begin
    int ledOn, ledOther;
    {rst, autoConfig, cfgWrite, cfgChan, cfgEnable, cfgHoldLast, cfgUnsigned} = 7'h40;
    cfgFallback = 16'h0000;
    wireBrokenPin = 2'b00;
    powerLostPin = 2'b00;
    void'($urandom(32'hc133dcfb));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("setpointUa1", setpointUa1, 16'h0fa0);
    for (int i = 0; i < 21; i++)
      pair(i < 9 ? sgn[i] : 16'($urandom), sgn[(i + 1) % 9], 1'b0, i % 3);
    $display("signed format test done");
    cfg(1'b0, 1'b1, 1'b0, 16'h0000, 1'b1);
    for (int i = 0; i < 16; i++)
      pair(i < 6 ? uns[i] : 16'($urandom), uns[(i + 2) % 6], 1'b1, i % 2);
    $display("unsigned format test done");
    auto();
    pair(16'h1000, 16'h2000, 1'b0, 1);
    isl.link(1'b0);
    repeat (5) @(posedge mclk);
    check("setpointUa0", setpointUa0, 16'h0fa0);
    isl.link(1'b1);
    cfg(1'b0, 1'b1, 1'b0, 16'h04d2, 1'b0);
    cfg(1'b1, 1'b1, 1'b1, 16'h2222, 1'b0);
    isl.link(1'b0);
    isl.sendPair(16'h3000, 16'h3000, 0);
    repeat (5) @(posedge mclk);
    check("setpointUa0", setpointUa0, expUa(16'h04d2, 1'b0));
    check("setpointUa1", setpointUa1, expUa(16'h2000, 1'b0));
    check("outWord0", outWord0, 16'h1000);
    isl.link(1'b1);
    repeat (5) @(posedge mclk);
    check("setpointUa0", setpointUa0, expUa(16'h1000, 1'b0));
    $display("fallback test done");
    cfg(1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    wireBrokenPin <= 2'b11;
    isl.sendPair(16'h0005, 16'h0005, 1);
    repeat (6) @(posedge mclk);
    check("outWord1", outWord1, 16'h2000);
    check("setpointUa1", setpointUa1, 16'h0000);
    check("statusWord1", statusWord1, 16'h0000);
    check("statusWord0", statusWord0, expSt(16'h0005, 1'b0, 1'b1));
    ledOn = 0;
    ledOther = 0;
    repeat (20)
    begin
      @(posedge mclk);
      ledOn += faultLed[0];
      ledOther += faultLed[1];
    end
    check("faultLed0 blinks", 16'(ledOn > 0 && ledOn < 20), 16'h0001);
    check("faultLed1 dark", 16'(ledOther), 16'h0000);
    wireBrokenPin <= 2'b00;
    powerLostPin <= 2'b01;
    repeat (6) @(posedge mclk);
    check("statusWord0", statusWord0, expSt(16'h0005, 1'b0, 1'b1));
    powerLostPin <= 2'b00;
    auto();
    pair(16'h0100, 16'h0200, 1'b0, 0);
    $display("enable and fault test done");
    conclude();
  end
endmodule
